// ---- design/interrupt_accept_and_mask_unit.sv ----
// Interrupt request, mask, edge select and acceptance logic
//
// How it works
// RQ1: Masks reset to ones; one blocks service.
// RQ2: Software writes ones to unused mask bits.
// RQ3: Software writes zeros to unused request bits.
// RQ4: Watchdog flag usable only in interval mode.
// RQ5: Watchdog mask reads undefined in reset modes.
// RQ6: Acknowledge clears the source request flag.
// RQ7: Output-mode level changes still raise requests.
// RQ8: Edge select resets zero, three two-bit fields.
// RQ9: Codes: fall, rise, both; one-zero prohibited.
// RQ10: Software masks, writes, clears flag, unmasks.
// RQ11: Status word resets 02, enable flag clear.
// RQ12: Accept pushes status, counter, clears enable.
// RQ13: Return or pop restores status word.
// RQ14: Key select enables pin group and pins.
// RQ15: Key select resets zero; pull-ups on inputs.
// RQ16: Software masks key before changing select.
// RQ17: Non-maskable wins, ignores enable flag.
// RQ18: Non-maskable may interrupt its own routine.
// RQ19: Maskable needs flag, no mask, enable.
// RQ20: Latency nine to nineteen clocks.
// RQ21: Simultaneous requests served by fixed priority.
// RQ22: Flags set on final clock wait one instruction.
// RQ23: Flag or mask access defers next acceptance.
// RQ24: Maskable nesting only after routine re-enables.
// RQ25: Watchdog first, key return last.
// RQ26: Pins sampled; detected edge sets flag.
`timescale 1ns/100ps
module interrupt_accept_and_mask_unit (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  input  wire logic        psw_wr,
  input  wire logic [7:0]  psw_wdata,
  input  wire logic        enable_interrupts_instr,
  input  wire logic        mask_all_instr,
  input  wire logic        psw_restore,
  input  wire logic [7:0]  psw_restore_data,
  input  wire logic        instr_end,
  input  wire logic        wdt_interval_mode,
  input  wire logic        watchdog_request,
  input  wire logic        serial_rx_request,
  input  wire logic        serial_tx_request,
  input  wire logic        timer8_request,
  input  wire logic        timer16_request,
  input  wire logic [2:0]  ext_pins,
  input  wire logic [7:0]  key_pins,
  input  wire logic [7:0]  port4_output_mode,
  output logic      [7:0]  program_status_word,
  output logic             ack_start,
  output logic             ack_nmi,
  output logic             push_psw,
  output logic             push_pc,
  output logic             load_vector,
  output logic      [15:0] vector_addr,
  output logic      [7:0]  saved_psw,
  output logic      [7:0]  key_pullup_en
);

  localparam int N = intc_pkg::NUM_SRC;

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic edge_hit(input logic [1:0] mode, input logic rise,
                                    input logic fall);
    logic hit;
    hit = 1'b0;
    unique case (mode)
      intc_pkg::EDGE_FALL: hit = fall;
      intc_pkg::EDGE_RISE: hit = rise;
      intc_pkg::EDGE_BOTH: hit = rise | fall;
      default:             hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [N-1:0] one_hot(input logic [intc_pkg::IDX_W-1:0] idx);
    logic [N-1:0] v;
    v = '0;
    v[idx] = 1'b1;
    return v;
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [N-1:0]           req_ff;
  logic [N-1:0]           nxt_req;
  logic [N-1:0]           mask_ff;
  logic [N-1:0]           nxt_mask;
  logic [7:0]             edge_sel_ff;
  logic [7:0]             key_sel_ff;
  logic [7:0]             psw_ff;
  logic [7:0]             nxt_psw;
  logic                   hold_ff;
  logic                   nmi_pend_ff;
  intc_pkg::ack_state_t   state_ff;
  intc_pkg::ack_state_t   nxt_state;
  logic                   ack_start_ff;
  logic                   ack_nmi_ff;
  logic                   push_psw_ff;
  logic                   push_pc_ff;
  logic                   load_vector_ff;
  logic [15:0]            vector_ff;
  logic [7:0]             saved_psw_ff;
  logic [7:0]             rdata_ff;
  logic [7:0]             pullup_ff;

  // ****************************************
  // Address decode
  // ****************************************
  wire hit_req_lo  = bus_addr == intc_pkg::ADDR_REQ_LOW;
  wire hit_req_hi  = bus_addr == intc_pkg::ADDR_REQ_HIGH;
  wire hit_mask_lo = bus_addr == intc_pkg::ADDR_MASK_LOW;
  wire hit_mask_hi = bus_addr == intc_pkg::ADDR_MASK_HIGH;
  wire hit_edge    = bus_addr == intc_pkg::ADDR_EDGE_SEL;
  wire hit_key     = bus_addr == intc_pkg::ADDR_KEY_SEL;
  wire flag_access = (bus_wr | bus_rd) &
                     (hit_req_lo | hit_req_hi | hit_mask_lo | hit_mask_hi);

  // ****************************************
  // Edge detection on pins
  // ****************************************
  logic [2:0] ext_rise;
  logic [2:0] ext_fall;
  logic [7:0] key_rise;
  logic [7:0] key_fall;

  // Pad level is sampled whatever the port mode, so output toggles count too
  edge_detect #(.WIDTH(intc_pkg::NUM_EXT)) u_ext_edge ( // RQ7 RQ26
    .clock     (clock),
    .nrst      (nrst),
    .pin_async (ext_pins),
    .rise      (ext_rise),
    .fall      (ext_fall)
  );

  edge_detect #(.WIDTH(intc_pkg::NUM_KEY)) u_key_edge ( // RQ26
    .clock     (clock),
    .nrst      (nrst),
    .pin_async (key_pins),
    .rise      (key_rise),
    .fall      (key_fall)
  );

  wire [7:0] key_en = {key_sel_ff[7:4], {4{key_sel_ff[0]}}}; // RQ14
  wire       key_hit = |(key_fall & key_en); // RQ14

  wire ext0_hit = edge_hit(edge_sel_ff[3:2], ext_rise[0], ext_fall[0]); // RQ9
  wire ext1_hit = edge_hit(edge_sel_ff[5:4], ext_rise[1], ext_fall[1]); // RQ9
  wire ext2_hit = edge_hit(edge_sel_ff[7:6], ext_rise[2], ext_fall[2]); // RQ9

  // ****************************************
  // Request events
  // ****************************************
  wire wdt_mask_ev = watchdog_request & wdt_interval_mode;
  wire wdt_nmi_ev  = watchdog_request & ~wdt_interval_mode;
  wire [N-1:0] set_ev = {key_hit, timer16_request, timer8_request,
                         serial_tx_request, serial_rx_request,
                         ext2_hit, ext1_hit, ext0_hit, wdt_mask_ev};

  // ****************************************
  // Acceptance decision
  // ****************************************
  logic                         pick_found;
  logic [intc_pkg::IDX_W-1:0]   pick_idx;

  wire ie       = psw_ff[intc_pkg::PSW_IE_BIT];
  // Only flags already stored are seen, so a final-clock set waits one instr
  wire [N-1:0] eligible = req_ff & ~mask_ff & {N{ie}}; // RQ19 RQ22 RQ24

  priority_pick #(.N(N), .IDX_W(intc_pkg::IDX_W)) u_pick ( // RQ21 RQ25
    .req   (eligible),
    .found (pick_found),
    .index (pick_idx)
  );

  // Access on the final clock must block that same boundary too
  wire hold_now  = hold_ff | flag_access; // RQ23
  wire can_take  = instr_end & ~hold_now & (state_ff == intc_pkg::ACK_IDLE); // RQ23
  wire take_nmi  = can_take & nmi_pend_ff; // RQ17 RQ18
  wire take_mask = can_take & ~nmi_pend_ff & pick_found; // RQ17 RQ19
  wire take      = take_nmi | take_mask;
  wire [N-1:0] ack_clr = take_mask ? one_hot(pick_idx) : '0; // RQ6

  // ****************************************
  // Request and mask flag next values
  // ****************************************
  always_comb begin
    nxt_req = req_ff;
    if (bus_wr && hit_req_lo) begin
      nxt_req[6:0] = bus_wdata[6:0];
    end
    if (bus_wr && hit_req_hi) begin
      nxt_req[7] = bus_wdata[7];
      nxt_req[8] = bus_wdata[0];
    end
    // New events win over clears from software or acknowledge
    nxt_req = (nxt_req & ~ack_clr) | set_ev; // RQ6
    if (!wdt_interval_mode) begin
      nxt_req[intc_pkg::SRC_WDT] = 1'b0; // RQ4
    end
  end

  always_comb begin
    nxt_mask = mask_ff;
    if (bus_wr && hit_mask_lo) begin
      nxt_mask[6:0] = bus_wdata[6:0];
    end
    if (bus_wr && hit_mask_hi) begin
      nxt_mask[7] = bus_wdata[7];
      nxt_mask[8] = bus_wdata[0];
    end
  end

  // ****************************************
  // Status word
  // ****************************************
  always_comb begin
    nxt_psw = psw_ff;
    if (psw_restore) begin
      nxt_psw = psw_restore_data; // RQ13
    end else if (psw_wr) begin
      nxt_psw = psw_wdata; // RQ11
    end else if (enable_interrupts_instr) begin
      nxt_psw[intc_pkg::PSW_IE_BIT] = 1'b1; // RQ11
    end else if (mask_all_instr) begin
      nxt_psw[intc_pkg::PSW_IE_BIT] = 1'b0; // RQ11
    end
    if (take) begin
      nxt_psw[intc_pkg::PSW_IE_BIT] = 1'b0; // RQ12
    end
  end

  // ****************************************
  // Acknowledge sequence
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      intc_pkg::ACK_IDLE: if (take) nxt_state = intc_pkg::ACK_PSW;
      intc_pkg::ACK_PSW:  nxt_state = intc_pkg::ACK_PC;
      intc_pkg::ACK_PC:   nxt_state = intc_pkg::ACK_VEC;
      intc_pkg::ACK_VEC:  nxt_state = intc_pkg::ACK_IDLE;
    endcase
  end

  // ****************************************
  // Read data
  // ****************************************
  // Mask bit of watchdog reads stored value; undefined for software in reset modes
  wire [7:0] rd_req_lo  = {1'b0, req_ff[6:0]}; // RQ3 RQ4
  wire [7:0] rd_req_hi  = {req_ff[7], 6'h00, req_ff[8]};
  wire [7:0] rd_mask_lo = {1'b1, mask_ff[6:0]}; // RQ2 RQ5
  wire [7:0] rd_mask_hi = {mask_ff[7], 6'h3F, mask_ff[8]};
  wire [7:0] rd_mux = hit_req_lo  ? rd_req_lo  :
                      hit_req_hi  ? rd_req_hi  :
                      hit_mask_lo ? rd_mask_lo :
                      hit_mask_hi ? rd_mask_hi :
                      hit_edge    ? edge_sel_ff :
                      hit_key     ? key_sel_ff  : 8'h00;

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      req_ff      <= '0;
      mask_ff     <= '1; // RQ1
      edge_sel_ff <= intc_pkg::EDGE_RESET; // RQ8
      key_sel_ff  <= intc_pkg::KEY_RESET; // RQ15
      psw_ff      <= intc_pkg::PSW_RESET; // RQ11
      rdata_ff    <= 8'h00;
    end else begin
      req_ff   <= nxt_req;
      mask_ff  <= nxt_mask;
      psw_ff   <= nxt_psw;
      rdata_ff <= bus_rd ? rd_mux : rdata_ff;
      if (bus_wr && hit_edge) begin
        edge_sel_ff <= bus_wdata & intc_pkg::EDGE_WR_MASK; // RQ8
      end
      if (bus_wr && hit_key) begin
        key_sel_ff <= bus_wdata & intc_pkg::KEY_WR_MASK; // RQ15
      end
    end
  end

  // Hold covers the accessing instruction's own end only
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hold_ff     <= 1'b0;
      nmi_pend_ff <= 1'b0;
    end else begin
      hold_ff     <= hold_now & ~instr_end; // RQ23
      nmi_pend_ff <= wdt_nmi_ev | (nmi_pend_ff & ~take_nmi); // RQ17 RQ18
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff       <= intc_pkg::ACK_IDLE;
      ack_start_ff   <= 1'b0;
      ack_nmi_ff     <= 1'b0;
      push_psw_ff    <= 1'b0;
      push_pc_ff     <= 1'b0;
      load_vector_ff <= 1'b0;
      vector_ff      <= 16'h0000;
      saved_psw_ff   <= intc_pkg::PSW_RESET;
      pullup_ff      <= 8'h00;
    end else begin
      state_ff       <= nxt_state;
      ack_start_ff   <= take; // RQ20
      push_psw_ff    <= take; // RQ12
      push_pc_ff     <= state_ff == intc_pkg::ACK_PSW; // RQ12
      load_vector_ff <= state_ff == intc_pkg::ACK_PC; // RQ12
      pullup_ff      <= key_en & ~port4_output_mode; // RQ15
      if (take) begin
        ack_nmi_ff   <= take_nmi;
        saved_psw_ff <= psw_ff; // RQ12
        vector_ff    <= take_nmi ? intc_pkg::VEC_NMI : intc_pkg::VEC_TABLE[pick_idx];
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign bus_rdata           = rdata_ff;
  assign program_status_word = psw_ff;
  assign ack_start           = ack_start_ff;
  assign ack_nmi             = ack_nmi_ff;
  assign push_psw            = push_psw_ff;
  assign push_pc             = push_pc_ff;
  assign load_vector         = load_vector_ff;
  assign vector_addr         = vector_ff;
  assign saved_psw           = saved_psw_ff;
  assign key_pullup_en       = pullup_ff;

endmodule // interrupt_accept_and_mask_unit

// ---- design/intc_pkg.sv ----
// Constants, register map and types of the interrupt acceptance unit
package intc_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [15:0] ADDR_REQ_LOW   = 16'hFFE0;
  localparam logic [15:0] ADDR_REQ_HIGH  = 16'hFFE1;
  localparam logic [15:0] ADDR_MASK_LOW  = 16'hFFE4;
  localparam logic [15:0] ADDR_MASK_HIGH = 16'hFFE5;
  localparam logic [15:0] ADDR_EDGE_SEL  = 16'hFFEC;
  localparam logic [15:0] ADDR_KEY_SEL   = 16'hFFF5;

  // ****************************************
  // Reset values and fixed bits
  // ****************************************
  localparam logic [7:0] MASK_RESET     = 8'hFF;
  localparam logic [7:0] REQ_RESET      = 8'h00;
  localparam logic [7:0] EDGE_RESET     = 8'h00;
  localparam logic [7:0] KEY_RESET      = 8'h00;
  localparam logic [7:0] PSW_RESET      = 8'h02;
  localparam logic [7:0] EDGE_WR_MASK   = 8'hFC;
  localparam logic [7:0] KEY_WR_MASK    = 8'hF1;
  localparam int         PSW_IE_BIT     = 7;

  // ****************************************
  // Sources, lowest index wins
  // ****************************************
  localparam int NUM_SRC   = 9;
  localparam int SRC_WDT   = 0;
  localparam int SRC_EXT0  = 1;
  localparam int SRC_SRX   = 4;
  localparam int SRC_STX   = 5;
  localparam int SRC_TM8   = 6;
  localparam int SRC_TM16  = 7;
  localparam int SRC_KEY   = 8;
  localparam int NUM_EXT   = 3;
  localparam int NUM_KEY   = 8;
  localparam int IDX_W     = 4;

  // ****************************************
  // Vector table entries
  // ****************************************
  localparam logic [15:0] VEC_NMI = 16'h0004;
  localparam logic [NUM_SRC-1:0][15:0] VEC_TABLE = {
    16'h002A, 16'h0014, 16'h0010, 16'h000E, 16'h000C,
    16'h000A, 16'h0008, 16'h0006, 16'h0004};

  // ****************************************
  // Edge selection codes
  // ****************************************
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  typedef enum logic [1:0] {
    ACK_IDLE = 2'b00,
    ACK_PSW  = 2'b01,
    ACK_PC   = 2'b10,
    ACK_VEC  = 2'b11
  } ack_state_t;

endpackage

// ---- design/edge_detect.sv ----
// Pin synchroniser with rising and falling edge pulses
`timescale 1ns/100ps
module edge_detect #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] sync1_ff;
  logic [WIDTH-1:0] sync2_ff;
  logic [WIDTH-1:0] prev_ff;
  logic [1:0]       primed_ff;

  // ****************************************
  // Two-stage sync, then compare with last sample
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1_ff  <= '1;
      sync2_ff  <= '1;
      prev_ff   <= '1;
      primed_ff <= 2'h0;
    end else begin
      sync1_ff  <= pin_async;
      sync2_ff  <= sync1_ff;
      prev_ff   <= sync2_ff;
      primed_ff <= {primed_ff[0], 1'b1};
    end
  end

  // No edges until sync2_ff holds real samples
  assign rise = primed_ff[1] ? (sync2_ff & ~prev_ff) : '0;
  assign fall = primed_ff[1] ? (~sync2_ff & prev_ff) : '0;

endmodule // edge_detect

// ---- design/priority_pick.sv ----
// Fixed priority picker, index 0 highest
`timescale 1ns/100ps
module priority_pick #(
  parameter int N     = 9,
  parameter int IDX_W = 4
) (
  input  wire logic [N-1:0]     req,
  output logic                  found,
  output logic      [IDX_W-1:0] index
);

  always_comb begin
    found = 1'b0;
    index = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        index = IDX_W'(i);
      end
    end
  end

endmodule // priority_pick

// ---- verification/interrupt_accept_and_mask_unit_checker.sv ----
// Port-level checks of the interrupt acceptance unit
`timescale 1ns/100ps
module interrupt_accept_and_mask_unit_checker (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic [15:0] bus_addr,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic        psw_wr,
  input wire logic        enable_interrupts_instr,
  input wire logic        mask_all_instr,
  input wire logic        psw_restore,
  input wire logic [7:0]  psw_restore_data,
  input wire logic        instr_end,
  input wire logic [7:0]  program_status_word,
  input wire logic        ack_start,
  input wire logic        ack_nmi,
  input wire logic        push_psw,
  input wire logic        push_pc,
  input wire logic        load_vector,
  input wire logic [15:0] vector_addr,
  input wire logic [7:0]  saved_psw
);
  // ****************************************
  // Helpers
  // ****************************************
  logic ie;
  logic hold_acc;
  assign ie = program_status_word[7];
  // Flag and mask addresses differ only in bits 0 and 2
  assign hold_acc = (bus_wr || bus_rd) && ((bus_addr & 16'hFFFA) == 16'hFFE0);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_push;
    push_psw ##1 push_pc ##1 load_vector;
  endsequence
  sequence s_quiet;
    !ack_start [*3];
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  AST_PUSH_ORDER: assert property (ack_start |-> s_push)
    else $error("push order broken");
  AST_IE_CLEARED: assert property (ack_start |-> !ie)
    else $error("enable flag not cleared on accept");
  AST_SAVED_WORD: assert property (ack_start |-> saved_psw == $past(program_status_word))
    else $error("saved status word wrong");
  AST_AT_INSTR_END: assert property (ack_start |-> $past(instr_end))
    else $error("accept without instruction end");
  AST_ONE_AT_A_TIME: assert property (ack_start |=> s_quiet)
    else $error("overlapping accepts");
  AST_IE_NEEDED: assert property (ack_start && !ack_nmi |-> $past(ie))
    else $error("maskable accepted with enable clear");
  AST_NMI_VECTOR: assert property (ack_start && ack_nmi |-> vector_addr == intc_pkg::VEC_NMI)
    else $error("wrong non-maskable vector");
  AST_HOLD: assert property (hold_acc && instr_end |=> !ack_start)
    else $error("accept despite flag access hold");
  AST_RESTORE: assert property (psw_restore && !instr_end |=>
    program_status_word == $past(psw_restore_data))
    else $error("status word not restored");
  AST_ENABLE: assert property (enable_interrupts_instr && !psw_restore && !psw_wr
    && !instr_end |=> ie)
    else $error("enable instruction lost");
  AST_DISABLE: assert property (mask_all_instr && !enable_interrupts_instr && !psw_restore
    && !psw_wr |=> !ie)
    else $error("disable instruction lost");
endmodule // interrupt_accept_and_mask_unit_checker

bind interrupt_accept_and_mask_unit interrupt_accept_and_mask_unit_checker chk_i (
  .clock, .nrst, .bus_addr, .bus_wr, .bus_rd, .psw_wr, .enable_interrupts_instr,
  .mask_all_instr, .psw_restore, .psw_restore_data, .instr_end, .program_status_word,
  .ack_start, .ack_nmi, .push_psw, .push_pc, .load_vector, .vector_addr, .saved_psw);

// ---- verification/cpu_model.sv ----
// Behavioural core: instruction end pulses, paused while an accept runs
`timescale 1ns/100ps
module cpu_model (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic [3:0] len,
  input  wire logic       ack_start,
  input  wire logic       load_vector,
  output logic            instr_end
);
  logic [3:0] cnt_ff;
  logic       busy_ff;
  // Final clock of an instruction of len clocks, 4 to 10
  assign instr_end = (cnt_ff == len - 4'h1) && !busy_ff && !ack_start;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_ff  <= 4'h0;
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (busy_ff || ack_start) && !load_vector;
      // Frozen during the push sequence, so no instruction end lands in it
      if (!busy_ff) begin
        cnt_ff <= (cnt_ff >= len - 4'h1) ? 4'h0 : cnt_ff + 4'h1;
      end
    end
  end
endmodule // cpu_model

// ---- verification/interrupt_accept_and_mask_unit_tb_top.sv ----
// Self-checking bench of the interrupt acceptance unit
`timescale 1ns/100ps
module interrupt_accept_and_mask_unit_tb_top;
  // ****************************************
  // Signals
  // ****************************************
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [7:0]  bus_wdata = 8'h00;
  logic        psw_wr = 1'b0;
  logic [7:0]  psw_wdata = 8'h00;
  logic        load_vector;
  logic        psw_restore = 1'b0;
  logic [7:0]  psw_restore_data = 8'h00;
  logic        wdt_interval_mode = 1'b1;
  logic [6:0]  ev = 7'h00;
  logic [2:0]  ext_pins = 3'h7;
  logic [7:0]  key_pins = 8'hFF;
  logic [7:0]  port4_output_mode = 8'h00;
  logic [3:0]  ilen = 4'h4;
  logic        instr_end;
  logic [7:0]  bus_rdata;
  logic [7:0]  program_status_word;
  logic [7:0]  saved_psw;
  logic [7:0]  key_pullup_en;
  logic        ack_start;
  logic        ack_nmi;
  logic [15:0] vector_addr;
  int          n_fail = 0;
  int          n_checks = 0;
  logic [15:0] vecs [5] = '{16'h0004, 16'h000C, 16'h000E, 16'h0010, 16'h0014};

  always #10 clock = ~clock;

  interrupt_accept_and_mask_unit dut (
    .clock, .nrst, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata,
    .psw_wr, .psw_wdata, .enable_interrupts_instr(ev[5]),
    .mask_all_instr(ev[6]), .psw_restore, .psw_restore_data, .instr_end,
    .wdt_interval_mode, .watchdog_request(ev[0]), .serial_rx_request(ev[1]),
    .serial_tx_request(ev[2]), .timer8_request(ev[3]), .timer16_request(ev[4]),
    .ext_pins, .key_pins, .port4_output_mode, .program_status_word, .ack_start,
    .ack_nmi, .push_psw(), .push_pc(), .load_vector, .vector_addr, .saved_psw,
    .key_pullup_en);
  cpu_model cpu (.clock, .nrst, .len(ilen), .ack_start, .load_vector,
    .instr_end);

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clock);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clock);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clock);
    bus_rd <= 1'b0;
    @(posedge clock);
    #1;
    chk("rdata", {8'h00, e}, {8'h00, bus_rdata});
  endtask
  // One-cycle pulses: 0 wdt, 1 srx, 2 stx, 3 tm8, 4 tm16, 5 enable, 6 disable
  task automatic pulse(input logic [6:0] v);
    @(posedge clock);
    ev <= v;
    @(posedge clock);
    ev <= 7'h00;
  endtask
  task automatic exp_ack(input logic e, input logic [15:0] v);
    logic s;
    s = 1'b0;
    repeat (30) begin
      @(posedge clock);
      #1;
      if (ack_start === 1'b1) begin
        s = 1'b1;
        break;
      end
    end
    chk("accept", {15'h0000, e}, {15'h0000, s});
    if (s) chk("vector", v, vector_addr);
    repeat (3) @(posedge clock);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    rd(16'hFFE4, 8'hFF);
    rd(16'hFFE5, 8'hFF);
    rd(16'hFFEC, 8'h00);
    rd(16'hFFF5, 8'h00);
    rd(16'hFF00, 8'h00);
    chk("psw", 16'h0002, {8'h00, program_status_word});
    wr(16'hFFF5, 8'hF1);
    port4_output_mode <= 8'h21;
    rd(16'hFFF5, 8'hF1);
    chk("pullup", 16'h00DE, {8'h00, key_pullup_en});
    @(posedge clock);
    port4_output_mode <= 8'h00;
    $display("test reset_and_select done");
    for (int c = 0; c < 4; c++) begin
      wr(16'hFFE4, 8'hFF);
      wr(16'hFFEC, {4'h0, c[1:0], 2'h0});
      wr(16'hFFE0, 8'h00);
      wr(16'hFFE4, 8'hFD);
      pulse(7'h20);
      ext_pins <= 3'h6;
      exp_ack(c == 0 || c == 3, 16'h0006);
      rd(16'hFFE0, 8'h00);
      pulse(7'h20);
      ext_pins <= 3'h7;
      exp_ack(c == 1 || c == 3, 16'h0006);
    end
    $display("test edge_codes done");
    wr(16'hFFE4, 8'h80);
    wr(16'hFFE5, 8'h7E);
    pulse(7'h40);
    pulse(7'h1F);
    pulse(7'h20);
    exp_ack(1'b1, vecs[0]);
    exp_ack(1'b0, 16'h0000);
    for (int i = 1; i < 5; i++) begin
      pulse(7'h20);
      exp_ack(1'b1, vecs[i]);
    end
    wr(16'hFFE4, 8'hFF);
    pulse(7'h28);
    exp_ack(1'b0, 16'h0000);
    wr(16'hFFE4, 8'hBF);
    exp_ack(1'b1, 16'h0010);
    $display("test priority_and_mask done");
    wr(16'hFFE5, 8'hFF);
    wr(16'hFFF5, 8'h01);
    wr(16'hFFE1, 8'h00);
    wr(16'hFFE5, 8'hFE);
    ilen <= 4'hA;
    pulse(7'h20);
    key_pins <= 8'hDF;
    exp_ack(1'b0, 16'h0000);
    key_pins <= 8'hDB;
    exp_ack(1'b1, 16'h002A);
    $display("test key_return done");
    ilen <= 4'h4;
    wdt_interval_mode <= 1'b0;
    pulse(7'h40);
    pulse(7'h01);
    exp_ack(1'b1, 16'h0004);
    chk("nmi", 16'h0001, {15'h0000, ack_nmi});
    chk("saved", 16'h0002, {8'h00, saved_psw});
    pulse(7'h01);
    exp_ack(1'b1, 16'h0004);
    wr(16'hFFE0, 8'h01);
    rd(16'hFFE0, 8'h00);
    @(posedge clock);
    psw_restore_data <= 8'h82;
    psw_restore <= 1'b1;
    @(posedge clock);
    psw_restore <= 1'b0;
    @(posedge clock);
    #1;
    chk("restore", 16'h0082, {8'h00, program_status_word});
    @(posedge clock);
    psw_wdata <= 8'h02;
    psw_wr <= 1'b1;
    @(posedge clock);
    psw_wr <= 1'b0;
    @(posedge clock);
    #1;
    chk("psw_wr", 16'h0002, {8'h00, program_status_word});
    $display("test nmi_and_restore done");
    final_report;
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    final_report;
  end
endmodule // interrupt_accept_and_mask_unit_tb_top
